// [pkg/rsf_cfg.svh]
// Constants of the receive status flag block: register offsets, bit fields,
// reset values and the bit-time divider.
// Assumes a single 100 MHz clock; included by its bare name.
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define RSF_REG_CONTROL 8'h03
`define RSF_REG_SERCTL 8'h06
`define RSF_REG_STATUS 8'h08
`define RSF_REG_DATA_A 8'h09
`define RSF_REG_VALID_A 8'h0a
`define RSF_REG_DATA_B 8'h0b
`define RSF_REG_VALID_B 8'h0c

// ****************************************
// Field positions and reset values
// ****************************************
`define RSF_TXEN_BIT 7
`define RSF_RXEN_BIT 6
`define RSF_ST_FULL 0
`define RSF_ST_EOF 1
`define RSF_ST_FLOW 2
`define RSF_ST_VALID 3
`define RSF_ST_CHB_SHIFT 4
`define RSF_CONTROL_RESET 8'h00
`define RSF_SERCTL_RESET 8'h01
`define RSF_BYTE_RESET 8'h00

// ****************************************
// Timing
// ****************************************
`define RSF_CLOCK_NS 10
`define RSF_BIT_TIME_NS 1000
`define RSF_BIT_DIV (`RSF_BIT_TIME_NS / `RSF_CLOCK_NS)
`define RSF_FIFO_DEPTH 16

`endif

// [pkg/rsf_pkg.sv]
// Types of the receive status flag block.
// Assumes rsf_cfg.svh for the numeric constants.
package rsf_pkg;

    // One bit time of one receive channel
    typedef struct packed {
        logic chanB;
        logic dataBit;
        logic bitValid;
    } rsf_bit_t;

    // One register access from the host port
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rsf_regreq_t;

endpackage : rsf_pkg

// [src/rsf_status_flags.sv]
// Receive bit assembly, data registers and status flags of a two-channel
// bit_serializer, plus the FIFO that buffers incoming bit times.
// Assumes the host port decoder delivers one-cycle register access strobes.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_cfg.svh"

// ****************************************
// Bit-time FIFO
// ****************************************
module rsf_fifo #(
    parameter int WIDTH = 3,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr, rdPtr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // Handshakes on both sides
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

    // Storage
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers and level; ready is registered so the top drives it from a flop
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'b0;
        end else begin
            if (push) begin
                wrPtr <= wrPtr + AW'(1);
            end
            if (pop) begin
                rdPtr <= rdPtr + AW'(1);
            end
            count <= next_count;
            inReady <= (next_count != (AW+1)'(DEPTH));
        end
    end
endmodule : rsf_fifo

// ****************************************
// Status flag top
// ****************************************
module rsf_status_flags (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Host register port
    input wire rsf_pkg::rsf_regreq_t regReq,
    output logic [7:0] regRdata,
    output logic regRdValid,
    // Receiver bit times
    input wire rsf_pkg::rsf_bit_t rxBit,
    input wire logic rxBitValid,
    output logic rxBitReady
);
    import rsf_pkg::*;

    logic [7:0] control, serCtl;
    logic [15:0] divCnt;
    logic bitTick, pop, fifoValid, rxEn;
    rsf_bit_t popBit;
    logic [7:0] shiftData [2];
    logic [7:0] shiftMask [2];
    logic [7:0] dataReg [2];
    logic [7:0] maskReg [2];
    logic [7:0] asmData [2];
    logic [7:0] asmMask [2];
    logic [7:0] idleCnt [2];
    logic [2:0] bitCnt [2];
    logic [1:0] started, held, full, eof, flow, allValid;
    logic [1:0] hit, xfer, eofEv, underEv, overEv;
    logic statusRd;

    // Address of a channel's data register
    function automatic logic [7:0] dataAddr(input int c);
        return (c != 0) ? `RSF_REG_DATA_B : `RSF_REG_DATA_A;
    endfunction : dataAddr

    // Packs one channel's four flags into a status nibble
    function automatic logic [3:0] packFlags(input logic f, input logic e,
                                             input logic v, input logic a);
        logic [3:0] n;
        n = 4'h0;
        n[`RSF_ST_FULL] = f;
        n[`RSF_ST_EOF] = e;
        n[`RSF_ST_FLOW] = v;
        n[`RSF_ST_VALID] = a;
        return n;
    endfunction : packFlags

    // ****************************************
    // Bit-time pacing and buffering
    // ****************************************

    // One-cycle enable per bit time; the FIFO drains only on it, so it can fill
    always_ff @(posedge clock) begin
        if (!nrst) begin
            divCnt <= 16'h0000;
            bitTick <= 1'b0;
        end else begin
            bitTick <= (divCnt == 16'((`RSF_BIT_DIV) - 1));
            divCnt <= (divCnt == 16'((`RSF_BIT_DIV) - 1)) ? 16'h0000 : divCnt + 16'h0001;
        end
    end

    assign pop = fifoValid && bitTick;
    assign rxEn = control[`RSF_RXEN_BIT];

    rsf_fifo #(
        .WIDTH($bits(rsf_bit_t)),
        .DEPTH(`RSF_FIFO_DEPTH)
    ) bitFifo (
        .clock(clock),
        .nrst(nrst),
        .inValid(rxBitValid),
        .inReady(rxBitReady),
        .inData(rxBit),
        .outValid(fifoValid),
        .outReady(bitTick),
        .outData(popBit)
    );

    // ****************************************
    // Event decode
    // ****************************************

    // Assembly and per-channel events; bits are dropped outside receive mode
    always_comb begin
        statusRd = regReq.rd && (regReq.addr == `RSF_REG_STATUS);
        for (int c = 0; c < 2; c++) begin
            hit[c] = pop && rxEn && (popBit.chanB == 1'(c));
            asmData[c] = shiftData[c];
            asmMask[c] = shiftMask[c];
            if (hit[c] && popBit.bitValid) begin
                asmData[c][bitCnt[c]] = popBit.dataBit;
                asmMask[c][bitCnt[c]] = 1'b1;
            end
            eofEv[c] = hit[c] && !popBit.bitValid && started[c]
                && ({1'b0, idleCnt[c]} + 9'h001 >= {1'b0, serCtl});
            xfer[c] = (hit[c] && popBit.bitValid && (bitCnt[c] == 3'h7))
                || (eofEv[c] && (bitCnt[c] != 3'h0));
            overEv[c] = xfer[c] && held[c];
            underEv[c] = regReq.rd && (regReq.addr == dataAddr(c)) && !held[c];
        end
    end

    // ****************************************
    // Registers and state
    // ****************************************

    // Host-writable control; the status address decodes to nothing on a write
    always_ff @(posedge clock) begin
        if (!nrst) begin
            control <= `RSF_CONTROL_RESET;
            serCtl <= `RSF_SERCTL_RESET;
        end else if (regReq.wr) begin
            if (regReq.addr == `RSF_REG_CONTROL) begin
                control <= regReq.wdata;
            end
            if (regReq.addr == `RSF_REG_SERCTL) begin
                serCtl <= regReq.wdata;
            end
        end
    end

    // Byte assembly and end-of-frame timing per channel
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int c = 0; c < 2; c++) begin
                shiftData[c] <= `RSF_BYTE_RESET;
                shiftMask[c] <= `RSF_BYTE_RESET;
                bitCnt[c] <= 3'h0;
                idleCnt[c] <= 8'h00;
            end
            started <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (xfer[c]) begin
                    shiftData[c] <= `RSF_BYTE_RESET;
                    shiftMask[c] <= `RSF_BYTE_RESET;
                    bitCnt[c] <= 3'h0;
                end else if (hit[c] && popBit.bitValid) begin
                    shiftData[c] <= asmData[c];
                    shiftMask[c] <= asmMask[c];
                    bitCnt[c] <= bitCnt[c] + 3'h1;
                end
                if (hit[c] && popBit.bitValid) begin
                    started[c] <= 1'b1;
                    idleCnt[c] <= 8'h00;
                end else if (eofEv[c]) begin
                    started[c] <= 1'b0; // Frame over, wait for the next valid bit
                    idleCnt[c] <= 8'h00;
                end else if (hit[c] && started[c]) begin
                    idleCnt[c] <= idleCnt[c] + 8'h01;
                end
            end
        end
    end

    // Data registers and their occupancy
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int c = 0; c < 2; c++) begin
                dataReg[c] <= `RSF_BYTE_RESET;
                maskReg[c] <= `RSF_BYTE_RESET;
            end
            held <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (xfer[c]) begin
                    dataReg[c] <= asmData[c];
                    maskReg[c] <= asmMask[c];
                    held[c] <= 1'b1;
                end else if (regReq.rd && (regReq.addr == dataAddr(c))) begin
                    held[c] <= 1'b0;
                end
            end
        end
    end

    // Sticky full, eof and flow flags; an event in the clearing cycle wins over the clear; valid follows each transfer
    always_ff @(posedge clock) begin
        if (!nrst) begin
            full <= 2'b00;
            eof <= 2'b00;
            flow <= 2'b00;
            allValid <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                full[c] <= xfer[c] || (full[c] && !statusRd);
                eof[c] <= eofEv[c] || (eof[c] && !statusRd);
                flow[c] <= overEv[c] || underEv[c] || (flow[c] && !statusRd);
                if (xfer[c]) begin
                    allValid[c] <= &asmMask[c];
                end
            end
        end
    end

    // Read data; flags read as zero unless the receive enable is set, valid flags drive no request
    always_ff @(posedge clock) begin
        if (!nrst) begin
            regRdata <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regReq.rd;
            if (regReq.rd) begin
                unique case (regReq.addr)
                    `RSF_REG_CONTROL: regRdata <= control;
                    `RSF_REG_SERCTL: regRdata <= serCtl;
                    `RSF_REG_STATUS: regRdata <= rxEn ? {packFlags(full[1], eof[1], flow[1],
                        allValid[1]), packFlags(full[0], eof[0], flow[0], allValid[0])}
                        : 8'h00;
                    `RSF_REG_DATA_A: regRdata <= dataReg[0];
                    `RSF_REG_VALID_A: regRdata <= maskReg[0];
                    `RSF_REG_DATA_B: regRdata <= dataReg[1];
                    `RSF_REG_VALID_B: regRdata <= maskReg[1];
                    default: regRdata <= 8'h00;
                endcase
            end
        end
    end
endmodule : rsf_status_flags

`default_nettype wire

// [sim/rsf_status_flags_assertions.sv]
// Port checker of the receive status flag block.
// Assumes it is bound to rsf_status_flags and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_cfg.svh"
module rsf_status_flags_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Host port and receiver port
    input wire rsf_pkg::rsf_regreq_t regReq,
    input wire logic [7:0] regRdata,
    input wire logic regRdValid,
    input wire rsf_pkg::rsf_bit_t rxBit,
    input wire logic rxBitValid,
    input wire logic rxBitReady
);
    import rsf_pkg::*;
    logic [7:0] ctl;
    logic [7:0] serCtl;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Shadows of host writes, so read data can be predicted
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctl <= `RSF_CONTROL_RESET;
            serCtl <= `RSF_SERCTL_RESET;
        end else if (regReq.wr && regReq.addr == `RSF_REG_CONTROL) begin
            ctl <= regReq.wdata;
        end else if (regReq.wr && regReq.addr == `RSF_REG_SERCTL) begin
            serCtl <= regReq.wdata;
        end
    end
    sequence s_stat_rd;
        regReq.rd && regReq.addr == `RSF_REG_STATUS;
    endsequence
    sequence s_ctl_rd;
        regReq.rd && regReq.addr == `RSF_REG_CONTROL;
    endsequence
    AST_RD_ANSWER: assert property (regReq.rd |=> regRdValid)
        else $error("read without answer");
    AST_NO_EXTRA: assert property (!regReq.rd |=> !regRdValid)
        else $error("answer without read");
    AST_RDATA_STANDS: assert property (!regReq.rd |=> $stable(regRdata))
        else $error("read data moved without read");
    AST_STATUS_OFF: assert property (s_stat_rd ##0 !ctl[`RSF_RXEN_BIT] |=> regRdata == 8'h00)
        else $error("status nonzero outside receive mode");
    AST_CTL_BACK: assert property (s_ctl_rd |=> regRdata == ctl)
        else $error("control readback wrong");
    AST_SERCTL_BACK: assert property (regReq.rd && regReq.addr == `RSF_REG_SERCTL |=> regRdata == serCtl)
        else $error("frame count readback wrong");
    AST_UNMAPPED: assert property (regReq.rd && regReq.addr > 8'h0c |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    AST_READY_RESET: assert property ($rose(nrst) |-> !rxBitReady)
        else $error("ready too early after reset");
    AST_READY_HOLD: assert property (rxBitReady && !rxBitValid |=> rxBitReady)
        else $error("ready fell without a push");
endmodule : rsf_status_flags_assertions
bind rsf_status_flags rsf_status_flags_assertions u_chk (.clock(clock), .nrst(nrst),
    .regReq(regReq), .regRdata(regRdata), .regRdValid(regRdValid), .rxBit(rxBit),
    .rxBitValid(rxBitValid), .rxBitReady(rxBitReady));
`default_nettype wire

// [sim/rsf_host_model.sv]
// Host microcontroller model: one-cycle register strobes.
// Assumes the bench calls rd and wr by hierarchical reference.
`timescale 1ns/100ps
`default_nettype none
module rsf_host_model (
    // Clock
    input wire logic clock,
    // Register port toward the block
    output var rsf_pkg::rsf_regreq_t regReq,
    input wire logic [7:0] regRdata,
    input wire logic regRdValid
);
    import rsf_pkg::*;
    initial regReq = '0;
    // Read: strobe taken at the next edge, answer stands one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(posedge clock);
        regReq <= '{1'b1, 1'b0, a, ~a};
        @(posedge clock);
        regReq <= '{1'b0, 1'b0, ~a, a}; // Released lines do not keep the old address
        #1;
        ok = regRdValid;
        d = regRdata;
    endtask : rd
    // Flags other than valid are only ever cleared by reading, never by a write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        regReq <= '{1'b0, 1'b1, a, d};
        @(posedge clock);
        regReq <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
endmodule : rsf_host_model
`default_nettype wire

// [sim/rsf_status_flags_tb_top.sv]
// Self-checking bench of the receive status flag block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_cfg.svh"
module rsf_status_flags_tb_top;
    import rsf_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    rsf_regreq_t regReq;
    logic [7:0] regRdata;
    logic regRdValid;
    rsf_bit_t rxBit = '0;
    logic rxBitValid = 1'b0;
    logic rxBitReady;
    int err_count = 0;
    int n_tests = 0;
    int n;
    logic [31:0] seed = 32'h00002c0c;
    logic [7:0] d;
    logic [7:0] got;
    logic ok;
    always #5 clock = ~clock;
    rsf_status_flags u_dut (.clock(clock), .nrst(nrst), .regReq(regReq),
        .regRdata(regRdata), .regRdValid(regRdValid), .rxBit(rxBit),
        .rxBitValid(rxBitValid), .rxBitReady(rxBitReady));
    rsf_host_model u_host (.clock(clock), .regReq(regReq), .regRdata(regRdata),
        .regRdValid(regRdValid));
    // ****************************************
    // Helpers
    // ****************************************
    // Xorshift step; a fixed seed keeps every run the same
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    // Status byte from channel nibbles {valid, flow, eof, full}
    function automatic logic [7:0] st(input logic [3:0] a, input logic [3:0] b);
        return {b, a};
    endfunction : st
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] act);
        n_tests++;
        if (act !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, act);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
        u_host.rd(a, got, ok);
        chk(nm, exp, (ok === 1'b1) ? got : 8'hxx);
    endtask : rdchk
    // Offer one bit time and hold it until the FIFO takes it
    task automatic push(input logic chB, input logic b, input logic v);
        @(posedge clock);
        rxBit <= '{chB, b, v};
        rxBitValid <= 1'b1;
        @(negedge clock);
        while (rxBitReady !== 1'b1) @(negedge clock);
        @(posedge clock);
        rxBitValid <= 1'b0;
        rxBit <= '{~chB, ~b, ~v};
    endtask : push
    task automatic bits(input logic chB, input logic [7:0] x, input int k);
        for (int i = 0; i < k; i++) push(chB, x[i], 1'b1);
    endtask : bits
    // Bit times are a fixed count of clocks, so waiting is by count
    task automatic ticks(input int k);
        repeat (k * `RSF_BIT_DIV) @(posedge clock);
    endtask : ticks
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rdchk(8'h08, 8'h00, "status off");
        rdchk(8'h20, 8'h00, "unmapped");
        rdchk(8'h06, 8'h01, "frame count");
        u_host.wr(8'h03, 8'hc0);
        u_host.wr(8'h06, 8'h02);
        rdchk(8'h03, 8'hc0, "control");
        $display("test registers done");
        d = rnd();
        bits(1'b0, d, 8);
        ticks(10);
        rdchk(8'h08, st(4'b1001, 4'b0000), "full A");
        rdchk(8'h09, d, "data A");
        rdchk(8'h0a, 8'hff, "mask A");
        rdchk(8'h08, st(4'b1000, 4'b0000), "cleared");
        u_host.rd(8'h09, got, ok);
        rdchk(8'h08, st(4'b1100, 4'b0000), "underflow A");
        rdchk(8'h08, st(4'b1000, 4'b0000), "flow cleared");
        $display("test channel A done");
        d = rnd();
        bits(1'b1, d, 8);
        ticks(10);
        rdchk(8'h08, st(4'b1000, 4'b1001), "full B");
        d = rnd();
        bits(1'b1, d, 3);
        push(1'b1, ~d[3], 1'b0);
        push(1'b1, d[4], 1'b0);
        ticks(7);
        rdchk(8'h08, st(4'b1000, 4'b0111), "eof B");
        rdchk(8'h0c, 8'h07, "mask B");
        u_host.rd(8'h0b, got, ok);
        chk("data B", d & 8'h07, got & 8'h07);
        u_host.wr(8'h08, 8'hff);
        rdchk(8'h08, st(4'b1000, 4'b0000), "read only");
        $display("test channel B done");
        n = 0;
        @(posedge clock);
        rxBit <= '{1'b0, 1'b1, 1'b1};
        rxBitValid <= 1'b1;
        repeat (24) begin
            @(negedge clock);
            if (rxBitReady === 1'b1) n++;
        end
        @(posedge clock);
        rxBitValid <= 1'b0;
        chk("fill count", 8'h01, {7'h00, n >= 16 && n <= 17});
        ticks(20);
        chk("drained", 8'h01, {7'h00, rxBitReady});
        rdchk(8'h08, st(4'b1101, 4'b0000), "overflow A");
        u_host.wr(8'h03, 8'h00);
        rdchk(8'h08, 8'h00, "rx off");
        $display("test fill done");
        wrap_up();
    end
    // Watchdog well beyond the expected run of about 4800 cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        $display("BAD watchdog expected end seen hang");
        wrap_up();
    end
endmodule : rsf_status_flags_tb_top
`default_nettype wire
